// >>> hdl/etc_defs.svh
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

`define ETC_CLK_MHZ 100
`define ETC_US_CYCLES (`ETC_CLK_MHZ)
`define ETC_ADDR_TRIG_SEL 4'h0
`define ETC_ADDR_EXP_MODE 4'h1
`define ETC_ADDR_POLARITY 4'h2
`define ETC_ADDR_EXP_TIME 4'h3
`define ETC_ADDR_DELAY 4'h4
`define ETC_ADDR_TIMER_DUR 4'h5
`define ETC_ADDR_ROI_W 4'h6
`define ETC_ADDR_ROI_H 4'h7
`define ETC_ADDR_LANES 4'h8
`define ETC_ADDR_RUN 4'h9
`define ETC_ADDR_STATUS 4'hA
`define ETC_ADDR_FRAMES 4'hB
`define ETC_RST_EXP_TIME 32'h0000_03E8
`define ETC_RST_ROI_W 16'h1400
`define ETC_RST_ROI_H 16'h1000
`define ETC_RST_TRIG_SEL 2'h1
`define ETC_RST_LANES 3'h1
`define ETC_PIX_PER_LANE_CYC 8'h08
`define ETC_ST_WAIT_BIT 0
`define ETC_ST_EXP_BIT 1
`define ETC_ST_RD_BIT 2
`define ETC_ST_DLY_BIT 3

`endif

// >>> hdl/etc_pkg.sv
package etc_pkg;
  typedef enum logic [1:0] {
    ETC_SRC_LINK = 2'h0,
    ETC_SRC_LINE = 2'h1,
    ETC_SRC_DELAYED = 2'h2
  } etc_src_t;
  typedef enum logic [3:0] {
    ETC_EXP_IDLE = 4'h1,
    ETC_EXP_DELAY = 4'h2,
    ETC_EXP_TIMED = 4'h4,
    ETC_EXP_WIDTH = 4'h8
  } etc_exp_state_t;
endpackage

// >>> hdl/etc_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_defs.svh"
module etc_readout
  import etc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] roiWidth,
  input wire logic [15:0] roiHeight,
  input wire logic [2:0] laneCount,
  output logic busy,
  output logic lineStrobe,
  output logic done
);
  logic [15:0] lineCnt_r, lineCnt_nxt;
  logic [15:0] pixCnt_r, pixCnt_nxt;
  logic busy_r, busy_nxt;

  // Each cycle advances more pixels when more lanes are in use.
  always_comb
  begin
    lineCnt_nxt = lineCnt_r;
    pixCnt_nxt = pixCnt_r;
    busy_nxt = busy_r;
    lineStrobe = 1'b0;
    done = 1'b0;
    if (start)
    begin
      busy_nxt = 1'b1;
      lineCnt_nxt = 16'h0000;
      pixCnt_nxt = 16'h0000;
    end
    else if (busy_r)
    begin
      if ({3'h0, pixCnt_r} + ({11'h000, `ETC_PIX_PER_LANE_CYC} * {16'h0000, laneCount}) >= {3'h0, roiWidth})
      begin
        pixCnt_nxt = 16'h0000;
        lineStrobe = 1'b1;
        if (lineCnt_r + 16'h0001 >= roiHeight)
        begin
          busy_nxt = 1'b0;
          done = 1'b1;
        end
        else
          lineCnt_nxt = lineCnt_r + 16'h0001;
      end
      else
        pixCnt_nxt = 16'(pixCnt_r + 16'(`ETC_PIX_PER_LANE_CYC * laneCount));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lineCnt_r <= 16'h0000;
      pixCnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end
    else
    begin
      lineCnt_r <= lineCnt_nxt;
      pixCnt_r <= pixCnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
endmodule // etc_readout
`default_nettype wire

// >>> hdl/etc_exposure_trigger_controller.sv
// Overview of operation
// - Delayed source waits programmed microseconds first.
// - Two styles: fixed duration, pulse width.
// - Fixed style: selected edge, programmed duration.
// - Fixed style ignores triggers during exposure.
// - Width style exposes between opposite edges.
// - New exposure may overlap running readout.
// - Overlap needs no control bit.
// - All lines start and stop together.
// - Readout starts right after exposure ends.
// - Exposure window output follows exposure.
// - Frame never shorter than exposure.
// - Readout time scales with region size.
// - More lanes give faster readout.
// - Polarity picks the starting edge.
// - Waiting status drops, then returns automatically.
// - Delayed width style uses timer duration.
`timescale 1ns/1ps
`default_nettype none
`include "etc_defs.svh"
module etc_exposure_trigger_controller
  import etc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic controlInputLine,
  input wire logic linkTrigger,
  output logic exposureActive,
  output logic allLinesExpose,
  output logic readoutActive,
  output logic readoutLineStrobe,
  output logic waitingForTrigger
);
  logic [1:0] trigSel_r, trigSel_nxt;
  logic expModeWidth_r, expModeWidth_nxt;
  logic polFalling_r, polFalling_nxt;
  logic [31:0] expTime_r, expTime_nxt;
  logic [31:0] delayUs_r, delayUs_nxt;
  logic [31:0] timerDur_r, timerDur_nxt;
  logic [15:0] roiW_r, roiW_nxt;
  logic [15:0] roiH_r, roiH_nxt;
  logic [2:0] lanes_r, lanes_nxt;
  logic run_r, run_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] frames_r, frames_nxt;
  logic lineSync1_r, lineSync2_r, lineLast_r, linkLast_r;
  logic lineSync1_nxt, lineSync2_nxt, lineLast_nxt, linkLast_nxt;
  etc_exp_state_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [6:0] usDiv_r, usDiv_nxt;
  logic selLevel, selLast, startEdge, endEdge, rdBusy, rdStart, usTick;

  // Write decode of the configuration registers.
  always_comb
  begin
    trigSel_nxt = trigSel_r;
    expModeWidth_nxt = expModeWidth_r;
    polFalling_nxt = polFalling_r;
    expTime_nxt = expTime_r;
    delayUs_nxt = delayUs_r;
    timerDur_nxt = timerDur_r;
    roiW_nxt = roiW_r;
    roiH_nxt = roiH_r;
    lanes_nxt = lanes_r;
    run_nxt = run_r;
    if (regWr)
    begin
      case (regAddr)
        `ETC_ADDR_TRIG_SEL: trigSel_nxt = regWdata[1:0];
        `ETC_ADDR_EXP_MODE: expModeWidth_nxt = regWdata[0];
        `ETC_ADDR_POLARITY: polFalling_nxt = regWdata[0];
        `ETC_ADDR_EXP_TIME: expTime_nxt = regWdata;
        `ETC_ADDR_DELAY: delayUs_nxt = regWdata;
        `ETC_ADDR_TIMER_DUR: timerDur_nxt = regWdata;
        `ETC_ADDR_ROI_W: roiW_nxt = regWdata[15:0];
        `ETC_ADDR_ROI_H: roiH_nxt = regWdata[15:0];
        `ETC_ADDR_LANES: lanes_nxt = (regWdata[2:0] == 3'h0) ? 3'h1 : regWdata[2:0];
        `ETC_ADDR_RUN: run_nxt = regWdata[0];
        default: ;
      endcase
    end
  end

  // Read data register; it stands for one cycle after the read strobe.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (regRd)
    begin
      case (regAddr)
        `ETC_ADDR_TRIG_SEL: rdata_nxt = {30'h0, trigSel_r};
        `ETC_ADDR_EXP_MODE: rdata_nxt = {31'h0, expModeWidth_r};
        `ETC_ADDR_POLARITY: rdata_nxt = {31'h0, polFalling_r};
        `ETC_ADDR_EXP_TIME: rdata_nxt = expTime_r;
        `ETC_ADDR_DELAY: rdata_nxt = delayUs_r;
        `ETC_ADDR_TIMER_DUR: rdata_nxt = timerDur_r;
        `ETC_ADDR_ROI_W: rdata_nxt = {16'h0, roiW_r};
        `ETC_ADDR_ROI_H: rdata_nxt = {16'h0, roiH_r};
        `ETC_ADDR_LANES: rdata_nxt = {29'h0, lanes_r};
        `ETC_ADDR_RUN: rdata_nxt = {31'h0, run_r};
        `ETC_ADDR_STATUS: rdata_nxt = {28'h0, st_r == ETC_EXP_DELAY, rdBusy, exposureActive, waitingForTrigger};
        `ETC_ADDR_FRAMES: rdata_nxt = frames_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trigSel_r <= `ETC_RST_TRIG_SEL;
      expModeWidth_r <= 1'b0;
      polFalling_r <= 1'b0;
      expTime_r <= `ETC_RST_EXP_TIME;
      delayUs_r <= 32'h0000_0000;
      timerDur_r <= `ETC_RST_EXP_TIME;
      roiW_r <= `ETC_RST_ROI_W;
      roiH_r <= `ETC_RST_ROI_H;
      lanes_r <= `ETC_RST_LANES;
      run_r <= 1'b0;
    end
    else
    begin
      trigSel_r <= trigSel_nxt;
      expModeWidth_r <= expModeWidth_nxt;
      polFalling_r <= polFalling_nxt;
      expTime_r <= expTime_nxt;
      delayUs_r <= delayUs_nxt;
      timerDur_r <= timerDur_nxt;
      roiW_r <= roiW_nxt;
      roiH_r <= roiH_nxt;
      lanes_r <= lanes_nxt;
      run_r <= run_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign regRdata = rdata_r;

  // Trigger synchroniser and history of the selected level.
  always_comb
  begin
    lineSync1_nxt = controlInputLine;
    lineSync2_nxt = lineSync1_r;
    lineLast_nxt = lineSync2_r;
    linkLast_nxt = linkTrigger;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lineSync1_r <= 1'b0;
      lineSync2_r <= 1'b0;
      lineLast_r <= 1'b0;
      linkLast_r <= 1'b0;
    end
    else
    begin
      lineSync1_r <= lineSync1_nxt;
      lineSync2_r <= lineSync2_nxt;
      lineLast_r <= lineLast_nxt;
      linkLast_r <= linkLast_nxt;
    end
  end

  always_comb
  begin
    selLevel = (trigSel_r == ETC_SRC_LINK) ? linkTrigger : lineSync2_r;
    selLast = (trigSel_r == ETC_SRC_LINK) ? linkLast_r : lineLast_r;
    startEdge = polFalling_r ? (selLast & ~selLevel) : (~selLast & selLevel);
    endEdge = polFalling_r ? (~selLast & selLevel) : (selLast & ~selLevel);
  end

  // One-cycle enable per microsecond from the divider of the timed states.
  assign usTick = (usDiv_r == 7'(`ETC_US_CYCLES - 1));

  // Exposure state machine; readout runs separately, so overlap is free.
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    usDiv_nxt = usDiv_r;
    frames_nxt = frames_r;
    rdStart = 1'b0;
    case (st_r)
      ETC_EXP_IDLE:
      begin
        if (run_r && startEdge)
        begin
          if (trigSel_r == ETC_SRC_DELAYED && delayUs_r != 32'h0)
          begin
            st_nxt = ETC_EXP_DELAY;
            cnt_nxt = delayUs_r;
            usDiv_nxt = 7'h00;
          end
          else if (expModeWidth_r && trigSel_r != ETC_SRC_DELAYED)
            st_nxt = ETC_EXP_WIDTH;
          else
          begin
            st_nxt = ETC_EXP_TIMED;
            cnt_nxt = (expModeWidth_r ? timerDur_r : expTime_r);
            usDiv_nxt = 7'h00;
          end
        end
      end
      ETC_EXP_DELAY:
      begin
        usDiv_nxt = usTick ? 7'h00 : usDiv_r + 7'h01;
        if (usTick)
        begin
          if (cnt_r <= 32'h1)
          begin
            st_nxt = ETC_EXP_TIMED;
            cnt_nxt = (expModeWidth_r ? timerDur_r : expTime_r);
          end
          else
            cnt_nxt = cnt_r - 32'h1;
        end
      end
      ETC_EXP_TIMED:
      begin
        // Further start edges are ignored here.
        usDiv_nxt = usTick ? 7'h00 : usDiv_r + 7'h01;
        if (usTick)
        begin
          if (cnt_r <= 32'h1)
          begin
            st_nxt = ETC_EXP_IDLE;
            rdStart = 1'b1;
            frames_nxt = frames_r + 32'h1;
          end
          else
            cnt_nxt = cnt_r - 32'h1;
        end
      end
      ETC_EXP_WIDTH:
      begin
        if (endEdge)
        begin
          st_nxt = ETC_EXP_IDLE;
          rdStart = 1'b1;
          frames_nxt = frames_r + 32'h1;
        end
      end
      default: st_nxt = ETC_EXP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ETC_EXP_IDLE;
      cnt_r <= 32'h0000_0000;
      usDiv_r <= 7'h00;
      frames_r <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      usDiv_r <= usDiv_nxt;
      frames_r <= frames_nxt;
    end
  end

  // Exposure and waiting outputs decode the state register directly; readoutActive follows the readout block.
  always_comb
  begin
    exposureActive = st_r[`ETC_ST_RD_BIT] | st_r[`ETC_ST_DLY_BIT];
    allLinesExpose = exposureActive;
    waitingForTrigger = run_r & (st_r == ETC_EXP_IDLE);
    readoutActive = rdBusy;
  end

  // A start while busy restarts the line count for the newer frame.
  etc_readout u_readout (
    .clk(clk),
    .rst(rst),
    .start(rdStart),
    .roiWidth(roiW_r),
    .roiHeight(roiH_r),
    .laneCount(lanes_r),
    .busy(rdBusy),
    .lineStrobe(readoutLineStrobe),
    .done()
  );
endmodule // etc_exposure_trigger_controller
`default_nettype wire

// >>> bench/etc_props.sv
`timescale 1ns/1ps
`default_nettype none
module etc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic exposureActive,
  input wire logic allLinesExpose,
  input wire logic readoutActive,
  input wire logic readoutLineStrobe,
  input wire logic waitingForTrigger
);
  logic runR;
  logic [1:0] selR;
  // Mirrors the run control bit and the trigger selector written by software.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      runR <= 1'b0;
      selR <= 2'h1;
    end
    else if (regWr && regAddr == 4'h9)
      runR <= regWdata[0];
    else if (regWr && regAddr == 4'h0)
      selR <= regWdata[1:0];
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_all; exposureActive == allLinesExpose; endproperty
  a_all: assert property (p_all)
    else $error("line exposure differs from window");
  property p_rdstart; $fell(exposureActive) |-> readoutActive; endproperty
  a_rdstart: assert property (p_rdstart)
    else $error("readout not started at exposure end");
  property p_rdcause; $rose(readoutActive) |-> $fell(exposureActive); endproperty
  a_rdcause: assert property (p_rdcause)
    else $error("readout started without exposure end");
  property p_strobe; readoutLineStrobe |-> readoutActive; endproperty
  a_strobe: assert property (p_strobe)
    else $error("line strobe outside readout");
  property p_wait; exposureActive |-> !waitingForTrigger; endproperty
  a_wait: assert property (p_wait)
    else $error("waiting while exposing");
  property p_run; waitingForTrigger |-> runR; endproperty
  a_run: assert property (p_run)
    else $error("waiting without run");
  property p_accept; $fell(waitingForTrigger) && runR && selR != 2'h2 |-> exposureActive; endproperty
  a_accept: assert property (p_accept)
    else $error("accepted trigger gave no exposure");
  property p_rdz; !regRd |=> regRdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz)
    else $error("read data without read");
endmodule // etc_props
bind etc_exposure_trigger_controller etc_props chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .exposureActive(exposureActive), .allLinesExpose(allLinesExpose), .readoutActive(readoutActive),
  .readoutLineStrobe(readoutLineStrobe), .waitingForTrigger(waitingForTrigger));
`default_nettype wire

// >>> bench/etc_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module etc_trig_src (
  input wire logic clk,
  output logic line,
  output logic link
);
  initial line = 1'b0;
  initial link = 1'b0;
  // Inverts one trigger for n cycles, then restores it; callers space pulses apart.
  // Moves one trigger to a steady level at the next rising edge.
  task automatic level(input bit onLink, input logic v);
    @(posedge clk);
    if (onLink)
      link <= v;
    else
      line <= v;
  endtask
  task automatic pulse(input bit onLink, input int n);
    @(posedge clk);
    if (onLink)
      link <= !link;
    else
      line <= !line;
    repeat (n) @(posedge clk);
    if (onLink)
      link <= !link;
    else
      line <= !line;
  endtask
endmodule // etc_trig_src
`default_nettype wire

// >>> bench/exposure_trigger_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module exposure_trigger_controller_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic controlInputLine;
  logic linkTrigger;
  logic exposureActive;
  logic allLinesExpose;
  logic readoutActive;
  logic readoutLineStrobe;
  logic waitingForTrigger;
  logic r;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int d;
  int w;
  int n;
  int ln;
  always #5 clk = ~clk;
  etc_trig_src src (.clk(clk), .line(controlInputLine), .link(linkTrigger));
  etc_exposure_trigger_controller uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .controlInputLine(controlInputLine),
    .linkTrigger(linkTrigger), .exposureActive(exposureActive), .allLinesExpose(allLinesExpose),
    .readoutActive(readoutActive), .readoutLineStrobe(readoutLineStrobe),
    .waitingForTrigger(waitingForTrigger));
  task automatic complete_run;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic cfg(input logic [31:0] sel, input logic [31:0] mode, input logic [31:0] pol);
    wr(4'h0, sel);
    wr(4'h1, mode);
    wr(4'h2, pol);
    wr(4'h9, 32'h1);
  endtask
  // Measures start delay, exposure width, readout length and line strobes in cycles.
  task automatic meas(input int lim);
    #1 d = 0;
    w = 0;
    n = 0;
    ln = 0;
    while (exposureActive !== 1'b1 && d < lim)
    begin
      @(posedge clk);
      #1 d++;
    end
    r = readoutActive;
    while (exposureActive === 1'b1 && w < 3000)
    begin
      @(posedge clk);
      #1 w++;
    end
    while (readoutActive === 1'b1 && n < 3000)
    begin
      ln += readoutLineStrobe;
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic t_timed;
    wr(4'h6, 32'h10);
    wr(4'h7, 32'h2);
    wr(4'h3, 32'h1);
    cfg(32'h1, 32'h0, 32'h0);
    rd(4'hA, 32'h1);
    fork
      src.pulse(1'b0, 30);
      begin
        repeat (60) @(posedge clk);
        src.pulse(1'b0, 10);
      end
      meas(2000);
    join
    chk(w, 100);
    chk(n, 4);
    chk(ln, 2);
    meas(1000);
    chk(w, 0);
    rd(4'hA, 32'h1);
  endtask
  task automatic t_width;
    src.level(1'b1, 1'b1);
    cfg(32'h0, 32'h1, 32'h1);
    fork
      src.pulse(1'b1, 40);
      meas(500);
    join
    chk(w, 40);
    chk(n, 4);
    chk(ln, 2);
  endtask
  task automatic t_delay;
    wr(4'h4, 32'h1);
    wr(4'h5, 32'h2);
    cfg(32'h2, 32'h1, 32'h0);
    src.level(1'b1, 1'b0);
    fork
      src.pulse(1'b0, 20);
      meas(1000);
    join
    chk({31'h0, d >= 100 && d <= 110}, 32'h1);
    chk(w, 200);
  endtask
  task automatic t_overlap;
    wr(4'h6, 32'h40);
    wr(4'h7, 32'h4);
    cfg(32'h0, 32'h1, 32'h0);
    src.pulse(1'b1, 20);
    repeat (5) @(posedge clk);
    fork
      src.pulse(1'b1, 40);
      meas(200);
    join
    chk({31'h0, r}, 32'h1);
    chk(w, 40);
    chk(n, 32);
    chk(ln, 4);
    wr(4'h8, 32'h2);
    fork
      src.pulse(1'b1, 20);
      meas(200);
    join
    chk(n, 16);
    chk(ln, 4);
    wr(4'h8, 32'h0);
    rd(4'h8, 32'h1);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h1);
    rd(4'h3, 32'h3E8);
    rd(4'h6, 32'h1400);
    rd(4'h7, 32'h1000);
    rd(4'hF, 32'h0);
    t_timed;
    t_width;
    t_delay;
    t_overlap;
    rd(4'hB, 32'h6);
    complete_run;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
endmodule // exposure_trigger_controller_bench
`default_nettype wire
